/* core/wdt_pkg.sv */
// Watchdog timer package: register map, fields, reset values, timing
package wdt_pkg;
    localparam int unsigned CNT_W = 32;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_COUNT = 12'h004;
    localparam logic [11:0] OFS_MATCH = 12'h008;
    localparam logic [11:0] OFS_PULSE = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_RELOAD = 12'h014;
    localparam int unsigned CTRL_RUN = 0;
    localparam int unsigned CTRL_WDOG = 1;
    localparam int unsigned CTRL_EXT = 2;
    localparam int unsigned CTRL_PAUSE = 3;
    localparam int unsigned ST_RSTFLAG = 0;
    localparam int unsigned ST_MATCH = 1;
    localparam int unsigned ST_PULSE = 2;
    localparam logic [31:0] RELOAD_KEY = 32'h0000A55A;
    localparam logic [31:0] MATCH_RST = 32'hFFFFFFFF;
    localparam logic [15:0] PULSE_RST = 16'h0010;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned INT_RST_MIN_CLKS = 10;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {WST_IDLE, WST_PULSE, WST_HOLD} wdt_state_t;
endpackage

/* core/wdt_top.sv */
// Watchdog timer with reset pulse generator behind an AXI4-Lite slave
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RULE_01: 32-bit counter advances every peripheral clock
// RULE_02: Match in watchdog mode drives match low
// RULE_03: Enable picks internal-only or pulsed external reset
// RULE_04: Missed reload resets chip internally
// RULE_05: Sticky flag records watchdog reset occurred
// RULE_06: Pause bit stops counting during core debug
// RULE_07: Timer mode: match gives no reset
// RULE_08: Software programs external pulse width
// RULE_09: Internal reset lasts at least ten clocks
// RULE_10: Software reloads counter before match distance
module wdt_top #(
    parameter int unsigned PULSE_W = 16
) (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic DEBUG_HALT,
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic MATCH_N,
    output logic CHIP_RESET_REQ,
    output logic RESET_OUTPUT_PIN_N
);
    localparam logic [4:0] INT_CNT_MAX = 5'(wdt_pkg::INT_RST_MIN_CLKS);

    // Debug halt comes from the core's domain boundary; synchronise
    logic dbg_s1_q, dbg_s2_q;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            dbg_s1_q <= 1'b0;
            dbg_s2_q <= 1'b0;
        end else begin
            dbg_s1_q <= DEBUG_HALT;
            dbg_s2_q <= dbg_s1_q;
        end
    end

    // Register bus state
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d;
    logic rvalid_q, rvalid_d;
    logic [11:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    // Block state
    logic [3:0] ctrl_q, ctrl_d;
    logic [31:0] cnt_q, cnt_d, match_q, match_d;
    logic [PULSE_W-1:0] pulse_q, pulse_d, pcnt_q, pcnt_d;
    logic [4:0] icnt_q, icnt_d;
    logic rstflag_q, rstflag_d, matched_q, matched_d;
    wdt_pkg::wdt_state_t st_q, st_d;

    logic wr_fire, rd_fire, hit, run, trip;
    logic [31:0] wval;

    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    assign S_AXI_AWREADY = !aw_hold_q;
    assign S_AXI_WREADY = !w_hold_q;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    // Byte-lane merge of write data onto a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign hit = (cnt_q == match_q);
    assign run = ctrl_q[wdt_pkg::CTRL_RUN] && !(ctrl_q[wdt_pkg::CTRL_PAUSE] && dbg_s2_q); // RULE_06
    // Plain timer mode never trips, so a match there only wraps on
    assign trip = hit && run && ctrl_q[wdt_pkg::CTRL_WDOG] && st_q == wdt_pkg::WST_IDLE; // RULE_07

    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        ctrl_d = ctrl_q;
        cnt_d = cnt_q;
        match_d = match_q;
        pulse_d = pulse_q;
        rstflag_d = rstflag_q;
        matched_d = matched_q;
        st_d = st_q;
        pcnt_d = pcnt_q;
        icnt_d = icnt_q;
        wval = 32'h00000000;
        if (S_AXI_AWVALID && !aw_hold_q) begin
            aw_hold_d = 1'b1;
            awaddr_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !w_hold_q) begin
            w_hold_d = 1'b1;
            wdata_d = S_AXI_WDATA;
            wstrb_d = S_AXI_WSTRB;
        end
        if (S_AXI_BVALID && S_AXI_BREADY) begin
            bvalid_d = 1'b0;
        end
        if (S_AXI_RVALID && S_AXI_RREADY) begin
            rvalid_d = 1'b0;
        end
        // Counter advances; match is latched while in watchdog mode
        if (run) begin
            cnt_d = cnt_q + 32'h00000001; // RULE_01
        end
        if (trip) begin
            matched_d = 1'b1; // RULE_02
            rstflag_d = 1'b1; // RULE_05
            if (ctrl_q[wdt_pkg::CTRL_EXT]) begin
                st_d = wdt_pkg::WST_PULSE; // RULE_03
                pcnt_d = pulse_q;
            end else begin
                st_d = wdt_pkg::WST_HOLD; // RULE_04
            end
            icnt_d = INT_CNT_MAX;
        end
        case (st_q)
            wdt_pkg::WST_IDLE: begin
            end
            wdt_pkg::WST_PULSE: begin
                if (pcnt_q > PULSE_W'(1)) begin
                    pcnt_d = pcnt_q - PULSE_W'(1); // RULE_08
                end else begin
                    st_d = wdt_pkg::WST_HOLD;
                end
            end
            wdt_pkg::WST_HOLD: begin
                if (icnt_q > 5'h01) begin
                    icnt_d = icnt_q - 5'h01; // RULE_09
                end else begin
                    st_d = wdt_pkg::WST_IDLE;
                    matched_d = 1'b0;
                    // Chip reset clears control and count, leaving the timer stopped
                    ctrl_d = 4'h0;
                    cnt_d = 32'h00000000;
                end
            end
            default: st_d = wdt_pkg::WST_IDLE;
        endcase
        if (wr_fire) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wdt_pkg::RESP_OKAY;
            case (awaddr_q)
                wdt_pkg::OFS_CTRL: begin
                    wval = merge({28'h0000000, ctrl_q}, wdata_q, wstrb_q);
                    ctrl_d = wval[3:0];
                end
                wdt_pkg::OFS_COUNT: cnt_d = merge(cnt_q, wdata_q, wstrb_q);
                wdt_pkg::OFS_MATCH: match_d = merge(match_q, wdata_q, wstrb_q);
                wdt_pkg::OFS_PULSE: begin
                    wval = merge(32'(pulse_q), wdata_q, wstrb_q);
                    pulse_d = wval[PULSE_W-1:0];
                end
                wdt_pkg::OFS_STATUS: begin
                    // Write one to clear; a reset event in the same cycle wins
                    if (wdata_q[wdt_pkg::ST_RSTFLAG] && wstrb_q[0] && !trip) begin
                        rstflag_d = 1'b0; // RULE_05
                    end
                end
                wdt_pkg::OFS_RELOAD: begin
                    if (wdata_q == wdt_pkg::RELOAD_KEY) begin
                        cnt_d = 32'h00000000; // RULE_10
                    end
                end
                default: bresp_d = wdt_pkg::RESP_SLVERR;
            endcase
        end
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rresp_d = wdt_pkg::RESP_OKAY;
            case (S_AXI_ARADDR)
                wdt_pkg::OFS_CTRL: rdata_d = {28'h0000000, ctrl_q};
                wdt_pkg::OFS_COUNT: rdata_d = cnt_q;
                wdt_pkg::OFS_MATCH: rdata_d = match_q;
                wdt_pkg::OFS_PULSE: rdata_d = 32'(pulse_q);
                wdt_pkg::OFS_STATUS: rdata_d = {29'h00000000, st_q == wdt_pkg::WST_PULSE,
                                                 matched_q, rstflag_q};
                wdt_pkg::OFS_RELOAD: rdata_d = 32'h00000000;
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = wdt_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'b00;
            ctrl_q <= 4'h0;
            cnt_q <= 32'h00000000;
            match_q <= wdt_pkg::MATCH_RST;
            pulse_q <= PULSE_W'(wdt_pkg::PULSE_RST);
            rstflag_q <= 1'b0;
            matched_q <= 1'b0;
            st_q <= wdt_pkg::WST_IDLE;
            pcnt_q <= '0;
            icnt_q <= 5'h00;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            ctrl_q <= ctrl_d;
            cnt_q <= cnt_d;
            match_q <= match_d;
            pulse_q <= pulse_d;
            rstflag_q <= rstflag_d;
            matched_q <= matched_d;
            st_q <= st_d;
            pcnt_q <= pcnt_d;
            icnt_q <= icnt_d;
        end
    end

    // Outputs are decoded from registered state only
    assign MATCH_N = !matched_q; // RULE_02
    assign CHIP_RESET_REQ = (st_q != wdt_pkg::WST_IDLE); // RULE_03
    assign RESET_OUTPUT_PIN_N = !(st_q == wdt_pkg::WST_PULSE); // RULE_08

    // Internal reset width: count how long the request stands
    logic [5:0] req_len_q;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            req_len_q <= 6'h00;
        end else if (CHIP_RESET_REQ) begin
            req_len_q <= (req_len_q == 6'h3F) ? req_len_q : req_len_q + 6'h01;
        end else begin
            req_len_q <= 6'h00;
        end
    end

    a_int_rst_width: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RULE_09
        $fell(CHIP_RESET_REQ) |-> req_len_q >= 6'(wdt_pkg::INT_RST_MIN_CLKS))
        else $error("internal reset shorter than ten clocks");
    a_match_wdog: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RULE_02
        trip |=> !MATCH_N)
        else $error("match in watchdog mode did not drive match low");
    a_timer_no_rst: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RULE_07
        (st_q == wdt_pkg::WST_IDLE && !ctrl_q[wdt_pkg::CTRL_WDOG]) |=> !CHIP_RESET_REQ)
        else $error("reset raised in plain timer mode");
    a_count_step: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RULE_01
        (run && !wr_fire && st_q == wdt_pkg::WST_IDLE) |=> cnt_q == $past(cnt_q) + 32'h1)
        else $error("counter did not advance");
    a_debug_pause: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RULE_06
        (ctrl_q[wdt_pkg::CTRL_PAUSE] && dbg_s2_q && !wr_fire && st_q == wdt_pkg::WST_IDLE)
        |=> $stable(cnt_q))
        else $error("counter moved while paused in debug");
    a_ext_pulse: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RULE_03
        $rose(CHIP_RESET_REQ) && ctrl_q[wdt_pkg::CTRL_EXT] |-> !RESET_OUTPUT_PIN_N)
        else $error("external reset pulse missing");
    a_int_only: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RULE_04
        $rose(CHIP_RESET_REQ) && !ctrl_q[wdt_pkg::CTRL_EXT] |-> RESET_OUTPUT_PIN_N)
        else $error("internal-only reset reached the pin");
    a_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RULE_05
        $rose(CHIP_RESET_REQ) |-> rstflag_q)
        else $error("reset flag not set on watchdog reset");
    a_pulse_len: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RULE_08
        $rose(CHIP_RESET_REQ) && !RESET_OUTPUT_PIN_N && pulse_q == PULSE_W'(16'h0003)
        |-> !RESET_OUTPUT_PIN_N [*3] ##1 RESET_OUTPUT_PIN_N)
        else $error("pulse width differs from programmed value");

    c_ext_reset: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        $fell(RESET_OUTPUT_PIN_N));
    c_int_reset: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        $rose(CHIP_RESET_REQ) && RESET_OUTPUT_PIN_N);
    c_pause: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        ctrl_q[wdt_pkg::CTRL_PAUSE] && dbg_s2_q && ctrl_q[wdt_pkg::CTRL_RUN]);
endmodule
`default_nettype wire

/* dv/wdt_rst_model.sv */
// Chip reset logic model: measures internal reset and reset pin pulses
`timescale 1ns/10ps
`default_nettype none
module wdt_rst_model (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CHIP_RESET_REQ,
    input wire logic RESET_OUTPUT_PIN_N,
    input wire logic MATCH_N,
    output logic [31:0] rst_cnt,
    output logic [31:0] req_len,
    output logic [31:0] pin_len,
    output logic [31:0] match_cyc
);
    logic [31:0] req_run;
    logic [31:0] pin_run;
    // A reset counts once it has ended, so its full width is known
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_cnt <= 32'h0;
            req_len <= 32'h0;
            pin_len <= 32'h0;
            match_cyc <= 32'h0;
            req_run <= 32'h0;
            pin_run <= 32'h0;
        end else begin
            if (CHIP_RESET_REQ === 1'b1) begin
                req_run <= req_run + 32'h1;
            end else if (req_run != 32'h0) begin
                req_len <= req_run;
                rst_cnt <= rst_cnt + 32'h1;
                req_run <= 32'h0;
            end
            if (RESET_OUTPUT_PIN_N === 1'b0) begin
                pin_run <= pin_run + 32'h1;
            end else if (pin_run != 32'h0) begin
                pin_len <= pin_run;
                pin_run <= 32'h0;
            end
            if (MATCH_N === 1'b0) begin
                match_cyc <= match_cyc + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Watchdog testbench: AXI4-Lite register tests against the reset model
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [31:0] RUN = 32'h1 << wdt_pkg::CTRL_RUN;
    localparam logic [31:0] WDG = 32'h1 << wdt_pkg::CTRL_WDOG;
    localparam logic [31:0] EXT = 32'h1 << wdt_pkg::CTRL_EXT;
    localparam logic [31:0] PAU = 32'h1 << wdt_pkg::CTRL_PAUSE;
    logic CORE_CLK = 1'b0, RSTN = 1'b0, DEBUG_HALT = 1'b0;
    logic [11:0] S_AXI_AWADDR = 12'h0, S_AXI_ARADDR = 12'h0;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'h0;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
    logic MATCH_N, CHIP_RESET_REQ, RESET_OUTPUT_PIN_N;
    logic [31:0] rst_cnt, req_len, pin_len, match_cyc, c1, c2;
    int error_cnt = 0, checks_done = 0;
    wdt_top uut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .DEBUG_HALT(DEBUG_HALT),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
        .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
        .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
        .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
        .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
        .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY), .MATCH_N(MATCH_N),
        .CHIP_RESET_REQ(CHIP_RESET_REQ), .RESET_OUTPUT_PIN_N(RESET_OUTPUT_PIN_N));
    wdt_rst_model model (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CHIP_RESET_REQ(CHIP_RESET_REQ),
        .RESET_OUTPUT_PIN_N(RESET_OUTPUT_PIN_N), .MATCH_N(MATCH_N), .rst_cnt(rst_cnt),
        .req_len(req_len), .pin_len(pin_len), .match_cyc(match_cyc));
    initial begin
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Signals move just after a rising edge; handshakes are judged on it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic b;
        b = 1'b0;
        @(posedge CORE_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= 4'hF;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        for (int i = 0; i < 100 && !b; i++) begin
            @(posedge CORE_CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
            b = (S_AXI_BVALID === 1'b1);
            if (b) begin
                r = S_AXI_BRESP;
                S_AXI_BREADY <= 1'b0;
            end
        end
        if (!b) chk(32'h0, 32'h1);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic b;
        b = 1'b0;
        d = 32'h0;
        @(posedge CORE_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        for (int i = 0; i < 100 && !b; i++) begin
            @(posedge CORE_CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
            b = (S_AXI_RVALID === 1'b1);
            if (b) begin
                d = S_AXI_RDATA;
                r = S_AXI_RRESP;
                S_AXI_RREADY <= 1'b0;
            end
        end
        if (!b) chk(32'h0, 32'h1);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    task automatic arm(input logic [31:0] m, input logic [31:0] c);
        wr(wdt_pkg::OFS_COUNT, 32'h0);
        wr(wdt_pkg::OFS_MATCH, m);
        wr(wdt_pkg::OFS_CTRL, c);
    endtask
    task automatic wait_rst(input logic [31:0] n);
        for (int i = 0; i < 3000 && rst_cnt !== n; i++) @(posedge CORE_CLK);
        chk(rst_cnt, n);
    endtask
    initial begin
        #(100 * 20000);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        @(posedge CORE_CLK);
        rchk(wdt_pkg::OFS_CTRL, 32'h0);
        rchk(wdt_pkg::OFS_COUNT, 32'h0);
        rchk(wdt_pkg::OFS_MATCH, wdt_pkg::MATCH_RST);
        rchk(wdt_pkg::OFS_PULSE, {16'h0, wdt_pkg::PULSE_RST});
        rchk(wdt_pkg::OFS_STATUS, 32'h0);
        rchk(12'h0FC, 32'h0);
        chk(r, wdt_pkg::RESP_SLVERR);
        wr(12'h0F8, 32'h1);
        chk(r, wdt_pkg::RESP_SLVERR);
        // Halt without pause bit must not stop the counter
        DEBUG_HALT <= 1'b1;
        arm(32'h00000014, RUN);
        rd(wdt_pkg::OFS_COUNT, c1);
        repeat (10) @(posedge CORE_CLK);
        rd(wdt_pkg::OFS_COUNT, c2);
        chk(32'((c2 - c1) >= 32'hA && (c2 - c1) < 32'h28), 32'h1);
        repeat (100) @(posedge CORE_CLK);
        chk(match_cyc, 32'h0);
        chk(rst_cnt, 32'h0);
        wr(wdt_pkg::OFS_CTRL, RUN | PAU);
        repeat (4) @(posedge CORE_CLK);
        rd(wdt_pkg::OFS_COUNT, c1);
        repeat (20) @(posedge CORE_CLK);
        rchk(wdt_pkg::OFS_COUNT, c1);
        DEBUG_HALT <= 1'b0;
        repeat (8) @(posedge CORE_CLK);
        rd(wdt_pkg::OFS_COUNT, c2);
        chk(32'(c2 != c1), 32'h1);
        // Reloads spaced well inside the match distance
        arm(32'h0000003C, RUN | WDG);
        repeat (6) begin
            repeat (20) @(posedge CORE_CLK);
            wr(wdt_pkg::OFS_RELOAD, wdt_pkg::RELOAD_KEY);
        end
        rchk(wdt_pkg::OFS_RELOAD, 32'h0);
        wr(wdt_pkg::OFS_CTRL, 32'h0);
        chk(rst_cnt, 32'h0);
        chk(match_cyc, 32'h0);
        arm(32'h0000001E, RUN | WDG);
        wait_rst(32'h1);
        chk(32'(req_len >= wdt_pkg::INT_RST_MIN_CLKS), 32'h1);
        chk(pin_len, 32'h0);
        chk(32'(match_cyc != 32'h0), 32'h1);
        rchk(wdt_pkg::OFS_CTRL, 32'h0);
        rchk(wdt_pkg::OFS_STATUS, 32'h1 << wdt_pkg::ST_RSTFLAG);
        wr(wdt_pkg::OFS_STATUS, 32'h1 << wdt_pkg::ST_RSTFLAG);
        rchk(wdt_pkg::OFS_STATUS, 32'h0);
        for (int k = 0; k < 2; k++) begin
            c2 = (k == 0) ? 32'h3 : 32'h7;
            wr(wdt_pkg::OFS_PULSE, c2);
            arm(32'h0000001E, RUN | WDG | EXT);
            wait_rst(32'h2 + 32'(k));
            chk(pin_len, c2);
            chk(req_len, c2 + wdt_pkg::INT_RST_MIN_CLKS);
            rchk(wdt_pkg::OFS_STATUS, 32'h1 << wdt_pkg::ST_RSTFLAG);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
